// [inc/cmo_pkg.sv]
/*
  Shared constants and types of the message object handler: register
  offsets, field positions, object and frame layouts, handler states.
  Assumes a 32-object message store and a byte-addressed register port.
*/
package cmo_pkg;

  localparam int N_OBJ = 32;
  localparam int ID_W = 29;
  localparam int ID_STD_LO = 18;
  localparam int DLC_W = 4;

  typedef logic [4:0] cmo_idx_t;
  typedef logic [5:0] cmo_num_t;

  localparam cmo_num_t OBJ_NUM_MIN = 6'h01;
  localparam cmo_num_t OBJ_NUM_MAX = 6'h20;
  localparam cmo_idx_t IDX_FIRST = 5'h00;
  localparam cmo_idx_t IDX_LAST = 5'h1f;
  localparam cmo_idx_t IDX_STEP = 5'h01;

  // Register offsets
  localparam logic [7:0] A_CMASK = 8'h00;
  localparam logic [7:0] A_CREQ = 8'h04;
  localparam logic [7:0] A_MASK = 8'h08;
  localparam logic [7:0] A_ARB = 8'h0c;
  localparam logic [7:0] A_MCON = 8'h10;
  localparam logic [7:0] A_DATA_A = 8'h14;
  localparam logic [7:0] A_DATA_B = 8'h18;

  // Command mask fields
  localparam int CM_WR = 7;
  localparam int CM_MASK = 6;
  localparam int CM_ARB = 5;
  localparam int CM_CTL = 4;
  localparam int CM_CLRINT = 3;
  localparam int CM_TXRQ = 2;
  localparam int CM_DA = 1;
  localparam int CM_DB = 0;

  // message_control_reg fields
  localparam int MC_FRESH_CONTENT_FLAG = 15;
  localparam int MC_OVERWRITE_LOST_FLAG = 14;
  localparam int MC_IRQ_PENDING_FLAG = 13;
  localparam int MC_USE_ACCEPTANCE_MASK = 12;
  localparam int MC_TRANSMIT_IRQ_ENABLE = 11;
  localparam int MC_RECEIVE_IRQ_ENABLE = 10;
  localparam int MC_REMOTE_ANSWER_ENABLE = 9;
  localparam int MC_TXRQ = 8;
  localparam int MC_EOB = 7;

  // Mask, arbitration and request register fields
  localparam int MK_MASK_SENSE_SELECT = 30;
  localparam int MK_MASK_WIDE_ID_SELECT = 31;
  localparam int AR_DIR = 29;
  localparam int AR_XTD = 30;
  localparam int AR_VAL = 31;
  localparam int CR_BUSY = 15;

  localparam logic [7:0] CMASK_RST = 8'h00;
  localparam logic [31:0] RD_IDLE = 32'h0000_0000;

  typedef struct packed {
    logic [ID_W-1:0] msk;
    logic mask_wide_id_select;
    logic mask_sense_select;
    logic object_valid;
    logic xtd;
    logic dir;
    logic [ID_W-1:0] id;
    logic [15:0] ctl;
    logic [31:0] data_b;
    logic [31:0] data_a;
  } cmo_obj_t;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic xtd;
    logic rtr;
    logic [DLC_W-1:0] dlc;
    logic [31:0] data_b;
    logic [31:0] data_a;
  } cmo_frame_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } cmo_bus_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_IF_RD = 4'b0001,
    S_IF_CHK = 4'b0010,
    S_RX_RD = 4'b0011,
    S_RX_CHK = 4'b0100,
    S_TX_RD = 4'b0101,
    S_TX_CHK = 4'b0110,
    S_TXD_RD = 4'b0111,
    S_TXD_CHK = 4'b1000
  } cmo_state_t;

endpackage

// [hdl/cmo_msg_ram.sv]
/*
  Message object store: one write port, one read port with registered
  read data. Assumes the caller never reads and writes one entry at once.
*/
`timescale 1ns/1ps
`default_nettype none

module cmo_msg_ram (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Read port
  input wire logic rd_en,
  input wire cmo_pkg::cmo_idx_t rd_addr,
  output var cmo_pkg::cmo_obj_t rd_q,
  // Write port
  input wire logic wr_en,
  input wire cmo_pkg::cmo_idx_t wr_addr,
  input wire cmo_pkg::cmo_obj_t wr_data
);

  cmo_pkg::cmo_obj_t mem [cmo_pkg::N_OBJ];
  cmo_pkg::cmo_obj_t q_r;
  cmo_pkg::cmo_obj_t q_nxt;

  always_comb begin
    q_nxt = rd_en ? mem[rd_addr] : q_r;
  end

  // Storage has no reset, like a real RAM macro
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign rd_q = q_r;

endmodule

`default_nettype wire

// [hdl/cmo_acc_match.sv]
/*
  Acceptance filter: compares one stored object with an incoming frame.
  Purely combinational; assumes the caller walks objects in number order.
*/
`timescale 1ns/1ps
`default_nettype none

module cmo_acc_match (
  // Stored object
  input wire cmo_pkg::cmo_obj_t obj,
  // Incoming frame
  input wire cmo_pkg::cmo_frame_t frm,
  // Result
  output logic hit
);

  logic [cmo_pkg::ID_W-1:0] care;
  logic use_m;
  logic id_ok;
  logic xtd_ok;
  logic dir_ok;
  logic locked;

  always_comb begin
    use_m = obj.ctl[cmo_pkg::MC_USE_ACCEPTANCE_MASK];
    care = use_m ? obj.msk : '1;
    // Standard frames only carry the upper identifier bits
    if (!frm.xtd) begin
      care[cmo_pkg::ID_STD_LO-1:0] = '0;
    end
    id_ok = ((obj.id ^ frm.id) & care) == '0;
    xtd_ok = (use_m && !obj.mask_wide_id_select) || (obj.xtd == frm.xtd);
    // Remote frames target transmit objects, data frames receive ones
    dir_ok = (use_m && !obj.mask_sense_select) || (obj.dir == frm.rtr);
    locked = !obj.ctl[cmo_pkg::MC_EOB] && obj.ctl[cmo_pkg::MC_FRESH_CONTENT_FLAG]
             && !frm.rtr;
    hit = obj.object_valid && id_ok && xtd_ok && dir_ok && !locked;
  end

endmodule

`default_nettype wire

// [hdl/cmo_top.sv]
/*
  Message handler for 32 message objects: interface buffer, transfers
  to and from the object store, acceptance scan and transmit selection.
  Assumes a protocol core that delivers one received frame per pulse,
  never faster than one scan, and loads one frame at a time.
*/
// Chosen here: strobed register access and the register addresses.
// Functional notes
// - Successful send with transmit interrupt enabled sets pending flag.
// - Matching remote frame with answer enabled sets send request.
// - Masks let groups of remote frames set send request.
// - Data bytes may be rewritten without clearing valid or request.
// - Command 0x87 updates data bytes and sets send request together.
// - Fresh flag keeps request alive; cleared when next send starts.
// - Stored standard data frames get zero lower eighteen identifier bits.
// - Stored data frame with receive interrupt enabled sets pending.
// - Storing a data frame writes length code and all eight bytes.
// - Masked receive objects accept groups of matching identifiers.
// - Software reads always see a consistent object snapshot.
// - Command 0x7F reads whole object, clears fresh and pending in store.
// - Lost flag marks overwritten message; hardware never clears it.
// - Send request on receive object sends a remote frame.
// - Matching data frame arriving first clears that send request.
// - Matching receive objects chain into a buffer, lowest first.
// - Objects 1 to 32; lower number wins transmit and receive.
// - Unread chained object that is not last refuses new data frames.
`timescale 1ns/1ps
`default_nettype none

module cmo_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire cmo_pkg::cmo_bus_t bus,
  output logic [31:0] rd_data,
  // Receive side of the protocol core
  input wire logic rx_valid,
  input wire cmo_pkg::cmo_frame_t rx_frame,
  // Transmit side of the protocol core
  input wire logic tx_ready,
  input wire logic tx_done,
  output logic tx_valid,
  output cmo_pkg::cmo_frame_t tx_frame
);

  cmo_pkg::cmo_state_t state_r, state_nxt;
  cmo_pkg::cmo_idx_t idx_r, idx_nxt;
  cmo_pkg::cmo_idx_t tx_obj_r, tx_obj_nxt;
  cmo_pkg::cmo_num_t creq_r, creq_nxt;
  logic [7:0] cmask_r, cmask_nxt;
  logic creq_pend_r, creq_pend_nxt;
  logic rx_pend_r, rx_pend_nxt;
  logic txd_pend_r, txd_pend_nxt;
  logic tx_valid_r, tx_valid_nxt;
  logic [31:0] rd_r, rd_nxt;
  cmo_pkg::cmo_obj_t buf_r, buf_nxt;
  cmo_pkg::cmo_frame_t rx_r, rx_nxt;
  cmo_pkg::cmo_frame_t txf_r, txf_nxt;

  cmo_pkg::cmo_obj_t ram_q, ram_wd, o;
  cmo_pkg::cmo_idx_t ram_ra;
  logic ram_rd, ram_we, hit, num_ok;

  cmo_msg_ram u_ram (
    .ref_clk(ref_clk),
    .rst(rst),
    .rd_en(ram_rd),
    .rd_addr(ram_ra),
    .rd_q(ram_q),
    .wr_en(ram_we),
    .wr_addr(idx_r),
    .wr_data(ram_wd)
  );

  cmo_acc_match u_match (
    .obj(ram_q),
    .frm(rx_r),
    .hit(hit)
  );

  assign num_ok = bus.wdata[5:0] >= cmo_pkg::OBJ_NUM_MIN
                  && bus.wdata[5:0] <= cmo_pkg::OBJ_NUM_MAX;

  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    tx_obj_nxt = tx_obj_r;
    creq_nxt = creq_r;
    cmask_nxt = cmask_r;
    creq_pend_nxt = creq_pend_r;
    rx_pend_nxt = rx_pend_r;
    txd_pend_nxt = txd_pend_r;
    tx_valid_nxt = tx_valid_r;
    rd_nxt = cmo_pkg::RD_IDLE;
    buf_nxt = buf_r;
    rx_nxt = rx_r;
    txf_nxt = txf_r;
    ram_rd = 1'b0;
    ram_ra = idx_r;
    ram_we = 1'b0;
    o = ram_q;
    // Buffer writes; a request while busy is dropped
    if (bus.wr) begin
      if (bus.addr == cmo_pkg::A_CMASK) begin
        cmask_nxt = bus.wdata[7:0];
      end else if (bus.addr == cmo_pkg::A_CREQ) begin
        if (!creq_pend_r && num_ok) begin
          creq_nxt = bus.wdata[5:0];
          creq_pend_nxt = 1'b1;
        end
      end else if (bus.addr == cmo_pkg::A_MASK) begin
        buf_nxt.msk = bus.wdata[cmo_pkg::ID_W-1:0];
        buf_nxt.mask_sense_select = bus.wdata[cmo_pkg::MK_MASK_SENSE_SELECT];
        buf_nxt.mask_wide_id_select = bus.wdata[cmo_pkg::MK_MASK_WIDE_ID_SELECT];
      end else if (bus.addr == cmo_pkg::A_ARB) begin
        buf_nxt.id = bus.wdata[cmo_pkg::ID_W-1:0];
        buf_nxt.dir = bus.wdata[cmo_pkg::AR_DIR];
        buf_nxt.xtd = bus.wdata[cmo_pkg::AR_XTD];
        buf_nxt.object_valid = bus.wdata[cmo_pkg::AR_VAL];
      end else if (bus.addr == cmo_pkg::A_MCON) begin
        buf_nxt.ctl = bus.wdata[15:0];
      end else if (bus.addr == cmo_pkg::A_DATA_A) begin
        buf_nxt.data_a = bus.wdata;
      end else if (bus.addr == cmo_pkg::A_DATA_B) begin
        buf_nxt.data_b = bus.wdata;
      end
    end
    if (bus.rd) begin
      if (bus.addr == cmo_pkg::A_CMASK) begin
        rd_nxt = 32'(cmask_r);
      end else if (bus.addr == cmo_pkg::A_CREQ) begin
        rd_nxt = 32'(creq_r);
        rd_nxt[cmo_pkg::CR_BUSY] = creq_pend_r;
      end else if (bus.addr == cmo_pkg::A_MASK) begin
        rd_nxt = {buf_r.mask_wide_id_select, buf_r.mask_sense_select, 1'b0, buf_r.msk};
      end else if (bus.addr == cmo_pkg::A_ARB) begin
        rd_nxt = {buf_r.object_valid, buf_r.xtd, buf_r.dir, buf_r.id};
      end else if (bus.addr == cmo_pkg::A_MCON) begin
        rd_nxt = 32'(buf_r.ctl);
      end else if (bus.addr == cmo_pkg::A_DATA_A) begin
        rd_nxt = buf_r.data_a;
      end else if (bus.addr == cmo_pkg::A_DATA_B) begin
        rd_nxt = buf_r.data_b;
      end
    end
    case (state_r)
      cmo_pkg::S_IDLE: begin
        // Software transfers first among pending jobs; a scan already running is finished first
        if (creq_pend_r) begin
          idx_nxt = cmo_pkg::cmo_idx_t'(creq_r - cmo_pkg::OBJ_NUM_MIN);
          state_nxt = cmo_pkg::S_IF_RD;
        end else if (rx_pend_r) begin
          idx_nxt = cmo_pkg::IDX_FIRST;
          state_nxt = cmo_pkg::S_RX_RD;
        end else if (txd_pend_r) begin
          idx_nxt = tx_obj_r;
          state_nxt = cmo_pkg::S_TXD_RD;
        end else if (tx_ready && !tx_valid_r) begin
          idx_nxt = cmo_pkg::IDX_FIRST;
          state_nxt = cmo_pkg::S_TX_RD;
        end
      end
      cmo_pkg::S_IF_RD: begin
        ram_rd = 1'b1;
        state_nxt = cmo_pkg::S_IF_CHK;
      end
      cmo_pkg::S_IF_CHK: begin
        // Whole object moves in one cycle: the snapshot stays coherent
        ram_we = 1'b1;
        if (cmask_r[cmo_pkg::CM_WR]) begin
          if (cmask_r[cmo_pkg::CM_MASK]) begin
            o.msk = buf_r.msk;
            o.mask_wide_id_select = buf_r.mask_wide_id_select;
            o.mask_sense_select = buf_r.mask_sense_select;
          end
          if (cmask_r[cmo_pkg::CM_ARB]) begin
            o.id = buf_r.id;
            o.xtd = buf_r.xtd;
            o.dir = buf_r.dir;
            o.object_valid = buf_r.object_valid;
          end
          if (cmask_r[cmo_pkg::CM_CTL]) begin
            o.ctl = buf_r.ctl;
          end
          if (cmask_r[cmo_pkg::CM_DA]) begin
            o.data_a = buf_r.data_a;
          end
          if (cmask_r[cmo_pkg::CM_DB]) begin
            o.data_b = buf_r.data_b;
          end
          if (cmask_r[cmo_pkg::CM_TXRQ]) begin
            o.ctl[cmo_pkg::MC_TXRQ] = 1'b1;
          end
        end else begin
          if (cmask_r[cmo_pkg::CM_MASK]) begin
            buf_nxt.msk = ram_q.msk;
            buf_nxt.mask_wide_id_select = ram_q.mask_wide_id_select;
            buf_nxt.mask_sense_select = ram_q.mask_sense_select;
          end
          if (cmask_r[cmo_pkg::CM_ARB]) begin
            buf_nxt.id = ram_q.id;
            buf_nxt.xtd = ram_q.xtd;
            buf_nxt.dir = ram_q.dir;
            buf_nxt.object_valid = ram_q.object_valid;
          end
          if (cmask_r[cmo_pkg::CM_CTL]) begin
            buf_nxt.ctl = ram_q.ctl;
          end
          if (cmask_r[cmo_pkg::CM_DA]) begin
            buf_nxt.data_a = ram_q.data_a;
          end
          if (cmask_r[cmo_pkg::CM_DB]) begin
            buf_nxt.data_b = ram_q.data_b;
          end
          // Buffer keeps the flags as they were before the clear
          if (cmask_r[cmo_pkg::CM_CLRINT]) begin
            o.ctl[cmo_pkg::MC_IRQ_PENDING_FLAG] = 1'b0;
          end
          if (cmask_r[cmo_pkg::CM_TXRQ]) begin
            o.ctl[cmo_pkg::MC_FRESH_CONTENT_FLAG] = 1'b0;
          end
        end
        creq_pend_nxt = 1'b0;
        state_nxt = cmo_pkg::S_IDLE;
      end
      cmo_pkg::S_RX_RD: begin
        ram_rd = 1'b1;
        state_nxt = cmo_pkg::S_RX_CHK;
      end
      cmo_pkg::S_RX_CHK: begin
        // Scan from object 1 upward: first hit wins, chains fill in order
        if (hit) begin
          ram_we = 1'b1;
          rx_pend_nxt = 1'b0;
          state_nxt = cmo_pkg::S_IDLE;
          if (!rx_r.rtr) begin
            o.id = rx_r.id;
            if (!rx_r.xtd) begin
              o.id[cmo_pkg::ID_STD_LO-1:0] = '0;
            end
            o.xtd = rx_r.xtd;
            o.ctl[cmo_pkg::DLC_W-1:0] = rx_r.dlc;
            o.data_a = rx_r.data_a;
            o.data_b = rx_r.data_b;
            o.ctl[cmo_pkg::MC_OVERWRITE_LOST_FLAG] = ram_q.ctl[cmo_pkg::MC_OVERWRITE_LOST_FLAG]
                                        | ram_q.ctl[cmo_pkg::MC_FRESH_CONTENT_FLAG];
            o.ctl[cmo_pkg::MC_FRESH_CONTENT_FLAG] = 1'b1;
            if (ram_q.ctl[cmo_pkg::MC_RECEIVE_IRQ_ENABLE]) begin
              o.ctl[cmo_pkg::MC_IRQ_PENDING_FLAG] = 1'b1;
            end
            o.ctl[cmo_pkg::MC_TXRQ] = 1'b0;
          end else if (ram_q.ctl[cmo_pkg::MC_REMOTE_ANSWER_ENABLE]) begin
            o.ctl[cmo_pkg::MC_TXRQ] = 1'b1;
          end else if (ram_q.ctl[cmo_pkg::MC_USE_ACCEPTANCE_MASK]) begin
            o.ctl[cmo_pkg::MC_TXRQ] = 1'b0;
            o.id = rx_r.id;
            o.xtd = rx_r.xtd;
            o.ctl[cmo_pkg::DLC_W-1:0] = rx_r.dlc;
            o.ctl[cmo_pkg::MC_FRESH_CONTENT_FLAG] = 1'b1;
          end
        end else if (idx_r == cmo_pkg::IDX_LAST) begin
          rx_pend_nxt = 1'b0;
          state_nxt = cmo_pkg::S_IDLE;
        end else begin
          idx_nxt = idx_r + cmo_pkg::IDX_STEP;
          state_nxt = cmo_pkg::S_RX_RD;
        end
      end
      cmo_pkg::S_TX_RD: begin
        ram_rd = 1'b1;
        state_nxt = cmo_pkg::S_TX_CHK;
      end
      cmo_pkg::S_TX_CHK: begin
        if (ram_q.object_valid && ram_q.ctl[cmo_pkg::MC_TXRQ]) begin
          txf_nxt.id = ram_q.id;
          txf_nxt.xtd = ram_q.xtd;
          txf_nxt.rtr = !ram_q.dir;
          txf_nxt.dlc = ram_q.ctl[cmo_pkg::DLC_W-1:0];
          txf_nxt.data_a = ram_q.data_a;
          txf_nxt.data_b = ram_q.data_b;
          tx_valid_nxt = 1'b1;
          tx_obj_nxt = idx_r;
          o.ctl[cmo_pkg::MC_FRESH_CONTENT_FLAG] = 1'b0;
          ram_we = 1'b1;
          state_nxt = cmo_pkg::S_IDLE;
        end else if (idx_r == cmo_pkg::IDX_LAST) begin
          state_nxt = cmo_pkg::S_IDLE;
        end else begin
          idx_nxt = idx_r + cmo_pkg::IDX_STEP;
          state_nxt = cmo_pkg::S_TX_RD;
        end
      end
      cmo_pkg::S_TXD_RD: begin
        ram_rd = 1'b1;
        state_nxt = cmo_pkg::S_TXD_CHK;
      end
      cmo_pkg::S_TXD_CHK: begin
        // A fresh flag set during the send keeps the request alive
        if (!ram_q.ctl[cmo_pkg::MC_FRESH_CONTENT_FLAG]) begin
          o.ctl[cmo_pkg::MC_TXRQ] = 1'b0;
        end
        if (ram_q.ctl[cmo_pkg::MC_TRANSMIT_IRQ_ENABLE]) begin
          o.ctl[cmo_pkg::MC_IRQ_PENDING_FLAG] = 1'b1;
        end
        ram_we = 1'b1;
        tx_valid_nxt = 1'b0;
        txd_pend_nxt = 1'b0;
        state_nxt = cmo_pkg::S_IDLE;
      end
      default: begin
        state_nxt = cmo_pkg::S_IDLE;
      end
    endcase
    // New events win over the clears above
    if (rx_valid) begin
      rx_nxt = rx_frame;
      rx_pend_nxt = 1'b1;
    end
    if (tx_done) begin
      txd_pend_nxt = 1'b1;
    end
    ram_wd = o;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= cmo_pkg::S_IDLE;
      idx_r <= cmo_pkg::IDX_FIRST;
      tx_obj_r <= cmo_pkg::IDX_FIRST;
      creq_r <= cmo_pkg::OBJ_NUM_MIN;
      cmask_r <= cmo_pkg::CMASK_RST;
      creq_pend_r <= 1'b0;
      rx_pend_r <= 1'b0;
      txd_pend_r <= 1'b0;
      tx_valid_r <= 1'b0;
      rd_r <= cmo_pkg::RD_IDLE;
      buf_r <= '0;
      rx_r <= '0;
      txf_r <= '0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      tx_obj_r <= tx_obj_nxt;
      creq_r <= creq_nxt;
      cmask_r <= cmask_nxt;
      creq_pend_r <= creq_pend_nxt;
      rx_pend_r <= rx_pend_nxt;
      txd_pend_r <= txd_pend_nxt;
      tx_valid_r <= tx_valid_nxt;
      rd_r <= rd_nxt;
      buf_r <= buf_nxt;
      rx_r <= rx_nxt;
      txf_r <= txf_nxt;
    end
  end

  assign rd_data = rd_r;
  assign tx_valid = tx_valid_r;
  assign tx_frame = txf_r;

  // Checks
  logic rx_store, wd_fresh_content_flag;
  assign rx_store = state_r == cmo_pkg::S_RX_CHK && hit;
  assign wd_fresh_content_flag = ram_wd.ctl[cmo_pkg::MC_FRESH_CONTENT_FLAG];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_creq;
    bus.wr && bus.addr == cmo_pkg::A_CREQ && !creq_pend_r && num_ok;
  endsequence
  sequence s_served;
    state_r == cmo_pkg::S_IF_CHK && ram_we;
  endsequence

  a_creq_served: assert property (s_creq |-> ##[1:200] s_served)
    else $error("object transfer not served in time");
  a_std_id_zero: assert property (rx_store && !rx_r.rtr && !rx_r.xtd
    |-> ram_we && ram_wd.id[cmo_pkg::ID_STD_LO-1:0] == '0)
    else $error("standard frame left low identifier bits");
  a_rx_store_flags: assert property (rx_store && !rx_r.rtr
    |-> wd_fresh_content_flag && !ram_wd.ctl[cmo_pkg::MC_TXRQ]
    && ram_wd.ctl[cmo_pkg::MC_IRQ_PENDING_FLAG] == (ram_q.ctl[cmo_pkg::MC_RECEIVE_IRQ_ENABLE]
    || ram_q.ctl[cmo_pkg::MC_IRQ_PENDING_FLAG]))
    else $error("receive flags wrong after store");
  a_lost_flag: assert property (ram_we && ram_q.ctl[cmo_pkg::MC_OVERWRITE_LOST_FLAG]
    && !(state_r == cmo_pkg::S_IF_CHK && cmask_r[cmo_pkg::CM_CTL])
    |-> ram_wd.ctl[cmo_pkg::MC_OVERWRITE_LOST_FLAG])
    else $error("lost flag cleared by hardware");
  a_remote_ans: assert property (rx_store && rx_r.rtr
    && ram_q.ctl[cmo_pkg::MC_REMOTE_ANSWER_ENABLE] |-> ram_wd.ctl[cmo_pkg::MC_TXRQ])
    else $error("remote frame did not set send request");
  a_tx_end: assert property (state_r == cmo_pkg::S_TXD_CHK
    |-> ram_wd.ctl[cmo_pkg::MC_TXRQ] == ram_q.ctl[cmo_pkg::MC_FRESH_CONTENT_FLAG]
    && (!ram_q.ctl[cmo_pkg::MC_TRANSMIT_IRQ_ENABLE] || ram_wd.ctl[cmo_pkg::MC_IRQ_PENDING_FLAG])
    ##1 !tx_valid)
    else $error("transmit completion mishandled");
  a_tx_start: assert property ($rose(tx_valid)
    |-> $past(ram_we) && !$past(wd_fresh_content_flag))
    else $error("fresh flag not cleared at send start");
  a_fifo_lock: assert property (state_r == cmo_pkg::S_RX_CHK && !rx_r.rtr
    && !ram_q.ctl[cmo_pkg::MC_EOB] && ram_q.ctl[cmo_pkg::MC_FRESH_CONTENT_FLAG]
    |-> !hit)
    else $error("locked chain object accepted a frame");
  a_data_update: assert property (state_r == cmo_pkg::S_IF_CHK
    && cmask_r == 8'h87 |-> ram_wd.ctl[cmo_pkg::MC_TXRQ]
    && ram_wd.data_a == buf_r.data_a && ram_wd.object_valid == ram_q.object_valid)
    else $error("data update did not set send request");

endmodule

`default_nettype wire

// [dv/cmo_core_model.sv]
/*
  Protocol core stand-in: hands received frames to the handler and
  completes every loaded frame once. Assumes frames are paced far apart.
*/
`timescale 1ns/1ps
`default_nettype none

module cmo_core_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Handler side
  input wire logic tx_valid,
  input wire cmo_pkg::cmo_frame_t tx_frame,
  output logic tx_ready,
  output logic tx_done,
  output logic rx_valid,
  output cmo_pkg::cmo_frame_t rx_frame,
  // Observation
  output cmo_pkg::cmo_frame_t last_tx,
  output int tx_cnt
);
  int dly;
  logic held;

  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
  end
  assign tx_ready = !held;

  // A slot on the wire takes a few cycles before success is known
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      held <= 1'b0;
      dly <= 0;
      tx_done <= 1'b0;
      tx_cnt <= 0;
      last_tx <= '0;
    end else begin
      tx_done <= 1'b0;
      if (!tx_valid) begin
        held <= 1'b0;
        dly <= 0;
      end else if (!held) begin
        dly <= dly + 1;
        if (dly == 6) begin
          tx_done <= 1'b1;
          held <= 1'b1;
          last_tx <= tx_frame;
          tx_cnt <= tx_cnt + 1;
        end
      end
    end
  end

  task send(input cmo_pkg::cmo_frame_t f);
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_frame <= f;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    // Stale frame must not look valid
    rx_frame <= ~f;
    repeat (80) @(posedge ref_clk);
  endtask
endmodule

`default_nettype wire

// [dv/cmo_tb.sv]
/*
  Self-checking bench of cmo_top: register tasks, frame traffic
  through the core stand-in. Assumes the register map of cmo_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
  n_compared++; \
  if ((a) !== (b)) begin \
    error_cnt++; \
    $display("Error t=%0t got=%h exp=%h", $time, (a), (b)); \
  end \
end

module testbench;
  localparam logic [28:0] I1 = 29'h048c0000;
  localparam logic [28:0] I2 = 29'h09140000;
  localparam logic [28:0] I3 = 29'h0d1c0000;
  localparam logic [31:0] DA = 32'ha1a2a3a4;
  localparam logic [31:0] DB = 32'hb1b2b3b4;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  cmo_pkg::cmo_bus_t bus = '0;
  logic [31:0] rd_data;
  logic [31:0] d;
  logic [31:0] ob [4];
  logic rx_valid, tx_ready, tx_done, tx_valid;
  cmo_pkg::cmo_frame_t rx_frame, tx_frame, last_tx;
  int tx_cnt;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;

  always #2 ref_clk = ~ref_clk;

  cmo_top dut (.ref_clk(ref_clk), .rst(rst), .bus(bus),
    .rd_data(rd_data), .rx_valid(rx_valid), .rx_frame(rx_frame),
    .tx_ready(tx_ready), .tx_done(tx_done), .tx_valid(tx_valid),
    .tx_frame(tx_frame));
  cmo_core_model core (.ref_clk(ref_clk), .rst(rst),
    .tx_valid(tx_valid), .tx_frame(tx_frame), .tx_ready(tx_ready),
    .tx_done(tx_done), .rx_valid(rx_valid), .rx_frame(rx_frame),
    .last_tx(last_tx), .tx_cnt(tx_cnt));

  task print_verdict;
    $display("errors=%0d compared=%0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Whole run needs a few thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      print_verdict;
    end
  end

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 d = rd_data;
  endtask

  task xf(input logic [7:0] cm, input logic [5:0] n);
    int i;
    wr(cmo_pkg::A_CMASK, {24'h0, cm});
    wr(cmo_pkg::A_CREQ, {26'h0, n});
    i = 0;
    do begin
      rd(cmo_pkg::A_CREQ);
      i++;
    end while (d[15] !== 1'b0 && i < 100);
    `CHK(d[15], 1'b0)
  endtask

  task setobj(input logic [31:0] arb, mc, a, b, input logic [5:0] n);
    wr(cmo_pkg::A_ARB, arb);
    wr(cmo_pkg::A_MCON, mc);
    wr(cmo_pkg::A_DATA_A, a);
    wr(cmo_pkg::A_DATA_B, b);
    xf(8'hf3, n);
  endtask

  // Arbitration, control, data A, data B sit at consecutive words
  task getobj(input logic [5:0] n);
    xf(8'h7f, n);
    for (int k = 0; k < 4; k++) begin
      rd(cmo_pkg::A_ARB + 8'(4 * k));
      ob[k] = d;
    end
  endtask

  task wait_tx(input int n);
    for (int k = 0; k < 300 && tx_cnt < n; k++) @(posedge ref_clk);
    `CHK(tx_cnt, n)
  endtask

  function automatic cmo_pkg::cmo_frame_t mkf(input logic [28:0] id,
      input logic r, input logic [31:0] a, b);
    return {id, 1'b0, r, 4'h8, b, a};
  endfunction

  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rd(cmo_pkg::A_CMASK);
    `CHK(d, 32'h0000_0000)
    rd(8'h1c);
    `CHK(d, 32'h0000_0000)
    // Store is not reset: invalidate every object first
    for (int n = 1; n <= 32; n++) xf(8'hf3, 6'(n));
    setobj({3'b101, I1}, 32'h0888, 32'h1122, 32'h3344, 6'h01);
    setobj({3'b100, I2}, 32'h0480, 32'h0, 32'h0, 6'h02);
    wr(cmo_pkg::A_DATA_A, DA);
    wr(cmo_pkg::A_DATA_B, DB);
    xf(8'h87, 6'h01);
    wait_tx(1);
    `CHK(last_tx, mkf(I1, 1'b0, DA, DB))
    repeat (4) @(posedge ref_clk);
    getobj(1);
    `CHK(ob[1][15:8], 8'h28)
    getobj(1);
    `CHK(ob[1][13], 1'b0)
    core.send(mkf(I2 | 29'h00abc, 1'b0, ~DA, ~DB));
    getobj(2);
    `CHK(ob[0], {3'b100, I2})
    `CHK(ob[1][15:0], 16'ha488)
    `CHK({ob[3], ob[2]}, {~DB, ~DA})
    repeat (2) core.send(mkf(I2, 1'b0, DA, DB));
    getobj(2);
    `CHK(ob[1][15:13], 3'b111)
    getobj(2);
    `CHK(ob[1][15:13], 3'b010)
    // Two-entry chain: object 3 open-ended, object 4 closes it
    setobj({3'b100, I3}, 32'h0408, 32'h0, 32'h0, 6'h03);
    setobj({3'b100, I3}, 32'h0488, 32'h0, 32'h0, 6'h04);
    core.send(mkf(I3, 1'b0, DA, DB));
    core.send(mkf(I3, 1'b0, ~DA, ~DB));
    getobj(4);
    `CHK({ob[1][15], ob[2]}, {1'b1, ~DA})
    getobj(3);
    `CHK({ob[1][15], ob[2]}, {1'b1, DA})
    wr(cmo_pkg::A_MCON, 32'h0a88);
    xf(8'h90, 6'h01);
    core.send(mkf(I1, 1'b1, 32'h0, 32'h0));
    wait_tx(2);
    `CHK(last_tx, mkf(I1, 1'b0, DA, DB))
    wr(cmo_pkg::A_MCON, 32'h0580);
    xf(8'h90, 6'h02);
    wait_tx(3);
    `CHK({last_tx.rtr, last_tx.id}, {1'b1, I2})
    print_verdict;
  end
endmodule

`default_nettype wire
